// File: bench/hotswap_fault_status_logic_tb.sv
// Self-checking bench of the hot-swap fault and status logic.
// Assumes short timing parameters; register bus is AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "hsf_params.svh"
module hotswap_fault_status_logic_tb import hsf_pkg::*;;
  localparam int QC = 20;
  localparam int GC = 4;
  localparam int UC = 8;
  localparam int SC = 10;
  logic aclk, aresetn;
  hsf_axi_req_s req;
  hsf_axi_rsp_s rsp;
  hsf_pins_s pins;
  logic [3:0] gate, good_out, oe_n, oc, sup, ton;
  logic [31:0] d;
  logic [1:0] r;
  int fails, comparisons, n;
  hsf_top #(.QUAL_CYC(24'(QC)), .GLITCH_CYC(24'(GC)), .UNLATCH_CYC(24'(UC)),
    .START_CYC(24'(SC))) dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
    .axi_rsp(rsp), .pins(pins), .gate_enable(gate), .good_out(good_out),
    .good_oe_n(oe_n));
  hsf_front_model fm (.gate_enable(gate), .oc_req(oc), .supply(sup),
    .turn_on(ton), .pins(pins));
  always #2 aclk = ~aclk;
  task automatic stop_test;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      fails++;
      stop_test();
    end
  endtask : tmo
  task automatic wait_rsp(input logic wrt);
    for (n = 0; n < 50 && !(wrt ? rsp.bvalid : rsp.rvalid); n++)
      @(posedge aclk);
    tmo(n, 50);
    if (wrt) req.bready <= 1'b1;
    else req.rready <= 1'b1;
    @(posedge aclk);
    d = rsp.rdata;
    r = wrt ? rsp.bresp : rsp.rresp;
    req.bready <= 1'b0;
    req.rready <= 1'b0;
  endtask : wait_rsp
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    req.awaddr <= a;
    req.wdata <= v;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    for (n = 0; n < 50 && (aw || w); n++) begin
      @(posedge aclk);
      if (aw && rsp.awready) begin
        aw = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w && rsp.wready) begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
    end
    tmo(n, 50);
    wait_rsp(1'b1);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (rsp.arready) break;
    end
    tmo(n, 50);
    req.arvalid <= 1'b0;
    wait_rsp(1'b0);
  endtask : rd
  task automatic wait_gate(input logic [3:0] exp, input int lim);
    for (n = 0; n < lim && gate !== exp; n++) @(posedge aclk);
    tmo(n, lim);
  endtask : wait_gate
  task automatic s_start;
    wait_gate(4'hF, 200);
    chk(32'(n >= QC), 32'h1);
    cyc(SC - 1);
    chk(oe_n, 4'h0);
    chk(good_out, 4'h0);
    cyc(1);
    chk(oe_n, 4'hF);
  endtask : s_start
  task automatic s_regs;
    rd(`HSF_OFS_CTRL);
    chk(d, `HSF_CTRL_RST);
    rd(12'h00C);
    chk(r, `HSF_RESP_DECERR);
    wr(12'h00C, 32'h0000_0000);
    chk(r, `HSF_RESP_DECERR);
    wr(`HSF_OFS_STARTUP_INTERVAL, 32'h0000_0007);
    chk(r, `HSF_RESP_OKAY);
    rd(`HSF_OFS_STARTUP_INTERVAL);
    chk(d, 32'h0000_0007);
  endtask : s_regs
  task automatic s_latch;
    oc <= 4'h1;
    cyc(6);
    chk(gate, 4'h0);
    chk(oe_n, 4'h0);
    oc <= 4'h0;
    cyc(2 * SC);
    chk(gate, 4'h0);
    ton <= 4'hE;
    cyc(UC - 3);
    ton <= 4'hF;
    cyc(20);
    chk(gate, 4'h0);
    ton <= 4'hE;
    cyc(UC + 4);
    ton <= 4'hF;
    wait_gate(4'hF, 60);
    chk(gate, 4'hF);
  endtask : s_latch
  task automatic s_retry;
    cyc(SC + 4);
    wr(`HSF_OFS_CTRL, 32'h0000_0010);
    cyc(4);
    chk(oe_n, 4'h0);
    oc <= 4'h2;
    cyc(6);
    chk(gate, 4'hD);
    chk(oe_n, 4'h2);
    oc <= 4'h0;
    cyc(64 * SC - 20);
    chk(gate, 4'hD);
    wait_gate(4'hF, 60);
    chk(gate, 4'hF);
    chk(32'(n > SC && n < 2 * SC), 32'h1);
    cyc(SC + 4);
    ton <= 4'hB;
    cyc(5);
    chk(oe_n, 4'h4);
    ton <= 4'hF;
  endtask : s_retry
  task automatic s_uv;
    cyc(SC + 8);
    sup <= 4'h0;
    cyc(2);
    sup <= 4'hF;
    cyc(8);
    chk(gate, 4'hF);
    sup <= 4'h0;
    cyc(GC + 6);
    sup <= 4'hF;
    cyc(2);
    chk(gate, 4'h0);
    wait_gate(4'hF, 100);
    chk(32'(n >= QC), 32'h1);
  endtask : s_uv
  task automatic s_track;
    wr(`HSF_OFS_CTRL, 32'h0000_0008);
    ton <= 4'h7;
    cyc(5);
    chk(gate, 4'h0);
    ton <= 4'hF;
    wait_gate(4'hF, 40);
    // Programmed interval of 7 cycles now rules, not the default
    cyc(7 - 1);
    chk(oe_n, 4'hF);
    cyc(1);
    chk(oe_n, 4'h0);
    rd(`HSF_OFS_STATUS);
    chk(d, 32'h0000_010F);
  endtask : s_track
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    req = '0;
    oc = 4'h0;
    sup = 4'hF;
    ton = 4'hF;
    fails = 0;
    comparisons = 0;
    cyc(8);
    aresetn <= 1'b1;
    s_start();
    s_regs();
    s_latch();
    s_retry();
    s_uv();
    s_track();
    stop_test();
  end
endmodule : hotswap_fault_status_logic_tb
bind hsf_top hsf_chk #(.QUAL_CYC(QUAL_CYC)) chk_i (.aclk(aclk),
  .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp), .pins(pins),
  .gate_enable(gate_enable), .good_out(good_out), .good_oe_n(good_oe_n));
`default_nettype wire

// File: bench/hsf_chk.sv
// Port checker of the hot-swap fault and status logic.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module hsf_chk import hsf_pkg::*; #(
  parameter logic [23:0] QUAL_CYC = 24'h14
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, active low
  input wire hsf_axi_req_s axi_req, // bus request
  input wire hsf_axi_rsp_s axi_rsp, // bus answer
  input wire hsf_pins_s pins, // comparator levels
  input wire logic [3:0] gate_enable, // gate drive
  input wire logic [3:0] good_out, // good pin level
  input wire logic [3:0] good_oe_n // good pin pull
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [23:0] up_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) up_cnt <= 24'h0;
    else if (up_cnt != 24'hFFFFFF) up_cnt <= up_cnt + 24'h1;
  end
  pin_low_a: assert property (good_out == 4'h0)
    else $error("good pin driven high");
  gate_qual_a: assert property (
    $rose(|gate_enable) |-> up_cnt >= QUAL_CYC)
    else $error("gate on before qualify delay");
  off_follow_a: assert property (
    !pins.turn_on_above[0] [*3] |=> !gate_enable[0])
    else $error("gate on while turn-on low");
  reset_idle_a: assert property ($rose(aresetn) |->
    gate_enable == 4'h0 && good_oe_n == 4'hF)
    else $error("outputs not idle after reset");
  b_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready |=>
    axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write answer dropped");
  r_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready |=>
    axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read answer dropped");
  b_answer_a: assert property (axi_req.awvalid && axi_rsp.awready &&
    axi_req.wvalid && axi_rsp.wready |-> ##2 axi_rsp.bvalid)
    else $error("write answer late");
  r_answer_a: assert property (axi_req.arvalid && axi_rsp.arready |=>
    axi_rsp.rvalid && !axi_rsp.arready)
    else $error("read answer late");
  aw_block_a: assert property (axi_rsp.bvalid |->
    !axi_rsp.awready && !axi_rsp.wready)
    else $error("write taken while answer pending");
  cover property ($rose(&gate_enable));
  cover property ($fell(|gate_enable));
  cover property (axi_rsp.rvalid && axi_rsp.rresp == 2'h3);
endmodule : hsf_chk
`default_nettype wire

// File: bench/hsf_front_model.sv
// Far side: supply, turn-on and sense comparators of four channels.
// Assumes the bench sets the levels; load current needs an open gate.
`timescale 1ns/1ns
`default_nettype none
module hsf_front_model import hsf_pkg::*; (
  input wire logic [3:0] gate_enable, // gate drive from the block
  input wire logic [3:0] oc_req, // load fault asked by the bench
  input wire logic [3:0] supply, // supplies above lockout
  input wire logic [3:0] turn_on, // turn-on levels, bench held
  output wire hsf_pins_s pins // comparator levels
);
  // Sense trips only through a conducting gate; rails stay power-ready
  // so a lockout dip is seen alone
  assign pins = '{supply_above_lockout: supply, supply_power_ready: 4'hF,
                  turn_on_above: turn_on, overcurrent: oc_req & gate_enable};
endmodule : hsf_front_model
`default_nettype wire

// File: core/hsf_params.svh
// Constants of the hot-swap fault and status logic: offsets, fields,
// reset values and timing counts.
// Assumes a single 250 MHz clock; counts are derived from printed times.
// Contract
// - Latched mode keeps a faulted channel's gate off; otherwise autoretry.
// - Polarity select low gives active-low good; else open-drain active high.
// - All supplies low past glitch filter restarts qualify delay and startup.
// - Turn-on held low for unlatch time clears latched fault, restarts start.
// - Autoretry turns gate off, restarts after sixty-four startup intervals.
// - Good asserts only after successful turn-on and full fault-free startup.
// - Good deasserts when turn-on is low or channel is off for a fault.
// - Grouped modes: any channel fault turns all gates and goods off.
// - Independent mode: each channel follows only its own fault state.
// - One supply above lockout for qualify delay before any startup.
// - Default startup interval is used when the timing input is unset.
`ifndef HSF_PARAMS_SVH
`define HSF_PARAMS_SVH
`define HSF_CLK_MHZ 250
`define HSF_T_QUAL_US 37500
`define HSF_T_GLITCH_US 10
`define HSF_T_UNLATCH_US 100
`define HSF_T_START_US 9000
`define HSF_RETRY_MULT 64
`define HSF_QUAL_CYC (`HSF_T_QUAL_US * `HSF_CLK_MHZ)
`define HSF_GLITCH_CYC (`HSF_T_GLITCH_US * `HSF_CLK_MHZ)
`define HSF_UNLATCH_CYC (`HSF_T_UNLATCH_US * `HSF_CLK_MHZ)
`define HSF_START_CYC (`HSF_T_START_US * `HSF_CLK_MHZ)
`define HSF_OFS_CTRL 12'h000
`define HSF_OFS_STARTUP_INTERVAL 12'h004
`define HSF_OFS_STATUS 12'h008
`define HSF_CTRL_LATCH 0
`define HSF_CTRL_POLHI 1
`define HSF_CTRL_MODE_LO 2
`define HSF_CTRL_TIMDEF 4
`define HSF_CTRL_RST 32'h0000_0017
`define HSF_RESP_OKAY 2'h0
`define HSF_RESP_DECERR 2'h3
`endif

// File: core/hsf_pkg.sv
// Types of the hot-swap fault and status logic.
// Assumes hsf_params.svh for the numeric constants.
package hsf_pkg;
  typedef enum logic [1:0] {
    HSF_INDEP = 2'h0,
    HSF_SEQ = 2'h1,
    HSF_TRACK = 2'h2
  } hsf_mode_e;
  typedef enum logic [4:0] {
    CH_OFF = 5'h01,
    CH_START = 5'h02,
    CH_ON = 5'h04,
    CH_LATCH = 5'h08,
    CH_RETRY = 5'h10
  } hsf_ch_e;
  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } hsf_axi_req_s;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } hsf_axi_rsp_s;
  typedef struct packed {
    logic [3:0] supply_above_lockout;
    logic [3:0] supply_power_ready;
    logic [3:0] turn_on_above;
    logic [3:0] overcurrent;
  } hsf_pins_s;
  typedef struct packed {
    hsf_pins_s meta;
    hsf_pins_s sync;
  } hsf_sync_s;
endpackage : hsf_pkg

// File: core/hsf_sync.sv
// Two-flop synchroniser for the analog comparator inputs.
// Assumes the inputs are asynchronous levels.
`timescale 1ns/1ns
`default_nettype none
module hsf_sync import hsf_pkg::*; (
  input wire logic aclk, // clock
  input wire logic aresetn, // synchronous reset, active low
  input wire hsf_pins_s pins_in, // raw comparator levels
  output hsf_pins_s pins_out // synchronised levels
);
  hsf_sync_s s;
  hsf_sync_s next_s;
  always_comb begin
    next_s.meta = pins_in;
    next_s.sync = s.meta;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign pins_out = s.sync;
endmodule : hsf_sync
`default_nettype wire

// File: core/hsf_top.sv
// Four-channel hot-swap fault management and status logic with an
// AXI4-Lite register slave.
// Assumes comparator levels arrive asynchronously from the analog front end.
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "hsf_params.svh"
module hsf_top import hsf_pkg::*; #(
  parameter logic [23:0] QUAL_CYC = 24'(`HSF_QUAL_CYC),
  parameter logic [23:0] GLITCH_CYC = 24'(`HSF_GLITCH_CYC),
  parameter logic [23:0] UNLATCH_CYC = 24'(`HSF_UNLATCH_CYC),
  parameter logic [23:0] START_CYC = 24'(`HSF_START_CYC)
) (
  input wire logic aclk, // clock, 250 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire hsf_axi_req_s axi_req, // AXI4-Lite master to slave
  output hsf_axi_rsp_s axi_rsp, // AXI4-Lite slave to master
  input wire hsf_pins_s pins, // comparator levels, asynchronous
  output logic [3:0] gate_enable, // pass-transistor gate drive on
  output logic [3:0] good_out, // channel-good pin level when driven
  output logic [3:0] good_oe_n // low while the good pin is pulled
);
  localparam logic [5:0] RETRY_LAST = 6'(`HSF_RETRY_MULT - 1);

  typedef struct packed {
    hsf_axi_rsp_s rsp;
    logic aw_got;
    logic w_got;
    logic [11:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [31:0] ctrl;
    logic [23:0] startup_interval;
    logic lockout_ok;
    logic [23:0] qual_cnt;
    logic [23:0] glitch_cnt;
    hsf_ch_e [3:0] ch;
    logic [3:0][23:0] cnt;
    logic [3:0][5:0] retry_cnt;
    logic [3:0] gate;
    logic [3:0] oe_n;
  } hsf_state_s;

  hsf_state_s s;
  hsf_state_s next_s;
  hsf_pins_s sp;

  hsf_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins_in(pins),
    .pins_out(sp)
  );

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic faulted(input hsf_ch_e st);
    return (st == CH_LATCH) || (st == CH_RETRY);
  endfunction : faulted

  logic latch_mode;
  logic pol_high;
  hsf_mode_e mode;
  logic [23:0] t_start;
  logic [3:0] good;
  logic [3:0] fault;
  logic any_fault;
  logic grouped;
  logic [3:0] cond;
  logic all_low;
  logic [31:0] status;

  always_comb begin
    latch_mode = s.ctrl[`HSF_CTRL_LATCH];
    pol_high = s.ctrl[`HSF_CTRL_POLHI];
    mode = hsf_mode_e'(s.ctrl[`HSF_CTRL_MODE_LO +: 2]);
    grouped = (mode != HSF_INDEP);
    // Default interval when the timing input is unset
    t_start = s.ctrl[`HSF_CTRL_TIMDEF] ? START_CYC : s.startup_interval;
    if (t_start == 24'h000000) begin
      t_start = 24'h000001;
    end
    for (int i = 0; i < 4; i++) begin
      good[i] = (s.ch[i] == CH_ON);
      fault[i] = faulted(s.ch[i]);
    end
    any_fault = |fault;
    all_low = ~|sp.supply_above_lockout;
    for (int i = 0; i < 4; i++) begin
      if (mode == HSF_INDEP) begin
        cond[i] = sp.supply_power_ready[i] & sp.turn_on_above[i];
      end else if (mode == HSF_TRACK) begin
        cond[i] = (&sp.supply_power_ready) & (&sp.turn_on_above);
      end else begin
        cond[i] = (&sp.supply_power_ready) & sp.turn_on_above[i];
      end
      cond[i] = cond[i] & s.lockout_ok;
    end
    status = {20'h00000, 3'h0, s.lockout_ok, fault, good};
  end

  always_comb begin
    next_s = s;
    // Write address and data are taken in either order
    if (axi_req.awvalid && s.rsp.awready) begin
      next_s.aw_got = 1'b1;
      next_s.waddr = axi_req.awaddr;
      next_s.rsp.awready = 1'b0;
    end
    if (axi_req.wvalid && s.rsp.wready) begin
      next_s.w_got = 1'b1;
      next_s.wdata = axi_req.wdata;
      next_s.wstrb = axi_req.wstrb;
      next_s.rsp.wready = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.rsp.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp = `HSF_RESP_OKAY;
      if (s.waddr[11:2] == `HSF_OFS_CTRL >> 2) begin
        next_s.ctrl = merge(s.ctrl, s.wdata, s.wstrb) & 32'h0000_001F;
      end else if (s.waddr[11:2] == `HSF_OFS_STARTUP_INTERVAL >> 2) begin
        next_s.startup_interval = 24'(merge({8'h00, s.startup_interval}, s.wdata, s.wstrb));
      end else if (s.waddr[11:2] == `HSF_OFS_STATUS >> 2) begin
        next_s.rsp.bresp = `HSF_RESP_OKAY;
      end else begin
        next_s.rsp.bresp = `HSF_RESP_DECERR;
      end
    end
    if (s.rsp.bvalid && axi_req.bready) begin
      next_s.rsp.bvalid = 1'b0;
      next_s.rsp.awready = 1'b1;
      next_s.rsp.wready = 1'b1;
    end
    if (axi_req.arvalid && s.rsp.arready) begin
      next_s.rsp.arready = 1'b0;
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rresp = `HSF_RESP_OKAY;
      if (axi_req.araddr[11:2] == `HSF_OFS_CTRL >> 2) begin
        next_s.rsp.rdata = s.ctrl;
      end else if (axi_req.araddr[11:2] == `HSF_OFS_STARTUP_INTERVAL >> 2) begin
        next_s.rsp.rdata = {8'h00, s.startup_interval};
      end else if (axi_req.araddr[11:2] == `HSF_OFS_STATUS >> 2) begin
        next_s.rsp.rdata = status;
      end else begin
        next_s.rsp.rdata = 32'h0000_0000;
        next_s.rsp.rresp = `HSF_RESP_DECERR;
      end
    end
    if (s.rsp.rvalid && axi_req.rready) begin
      next_s.rsp.rvalid = 1'b0;
      next_s.rsp.arready = 1'b1;
    end

    // Lockout qualification; brief dips while qualifying restart it
    if (all_low) begin
      next_s.qual_cnt = 24'h000000;
      if (s.glitch_cnt >= GLITCH_CYC - 24'h000001) begin
        next_s.lockout_ok = 1'b0;
      end else begin
        next_s.glitch_cnt = s.glitch_cnt + 24'h000001;
      end
    end else begin
      next_s.glitch_cnt = 24'h000000;
      if (!s.lockout_ok) begin
        if (s.qual_cnt >= QUAL_CYC - 24'h000001) begin
          next_s.lockout_ok = 1'b1;
        end else begin
          next_s.qual_cnt = s.qual_cnt + 24'h000001;
        end
      end
    end

    for (int i = 0; i < 4; i++) begin
      next_s.cnt[i] = s.cnt[i] + 24'h000001;
      case (s.ch[i])
        CH_OFF: begin
          next_s.cnt[i] = 24'h000000;
          if (cond[i] && !(grouped && any_fault)) begin
            next_s.ch[i] = CH_START;
          end
        end
        CH_START: begin
          // Overcurrent here is handled by the analog current limit
          if (!cond[i] || (grouped && any_fault)) begin
            next_s.ch[i] = CH_OFF;
          end else if (s.cnt[i] >= t_start - 24'h000001) begin
            next_s.ch[i] = CH_ON;
          end
        end
        CH_ON: begin
          next_s.cnt[i] = 24'h000000;
          next_s.retry_cnt[i] = 6'h00;
          if (sp.overcurrent[i]) begin
            next_s.ch[i] = latch_mode ? CH_LATCH : CH_RETRY;
          end else if (!cond[i] || (grouped && any_fault)) begin
            next_s.ch[i] = CH_OFF;
          end
        end
        CH_LATCH: begin
          if (sp.turn_on_above[i]) begin
            next_s.cnt[i] = 24'h000000;
          end else if (s.cnt[i] >= UNLATCH_CYC - 24'h000001) begin
            next_s.ch[i] = CH_OFF;
          end
        end
        CH_RETRY: begin
          if (s.cnt[i] >= t_start - 24'h000001) begin
            next_s.cnt[i] = 24'h000000;
            next_s.retry_cnt[i] = s.retry_cnt[i] + 6'h01;
            if (s.retry_cnt[i] == RETRY_LAST) begin
              next_s.ch[i] = CH_OFF;
            end
          end
        end
        default: begin
          next_s.ch[i] = CH_OFF;
        end
      endcase
    end

    for (int i = 0; i < 4; i++) begin
      next_s.gate[i] = (next_s.ch[i] == CH_START) || (next_s.ch[i] == CH_ON);
      // Pull the pin when asserted-low or when deasserted-high
      next_s.oe_n[i] = pol_high ? (next_s.ch[i] == CH_ON)
                                : (next_s.ch[i] != CH_ON);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.rsp.awready <= 1'b1;
      s.rsp.wready <= 1'b1;
      s.rsp.arready <= 1'b1;
      s.ctrl <= `HSF_CTRL_RST;
      s.startup_interval <= 24'(`HSF_START_CYC);
      s.ch <= '{CH_OFF, CH_OFF, CH_OFF, CH_OFF};
      s.oe_n <= 4'hF;
    end else begin
      s <= next_s;
    end
  end

  assign axi_rsp = s.rsp;
  assign gate_enable = s.gate;
  assign good_out = 4'h0;
  assign good_oe_n = s.oe_n;
endmodule : hsf_top
`default_nettype wire
